// ==== design/ilb_defs.svh ====
// Register offsets, field positions and reset values of the event latch bank
`ifndef ILB_DEFS_SVH
`define ILB_DEFS_SVH
`define ILB_IDX_SHORT      16'h190b
`define ILB_IDX_ON_DONE    16'h190c
`define ILB_IDX_OFF_DONE   16'h190d
`define ILB_IDX_THERMAL    16'h190e
`define ILB_IDX_GPIO_LOW   16'h1910
`define ILB_IDX_GPIO_MID   16'h1911
`define ILB_ADDR_W         18
`define ILB_REG_RESET      16'h0000
`define ILB_BIT_SPK_R      7
`define ILB_BIT_SPK_L      6
`define ILB_HP_MSB         5
`define ILB_BIT_TH_WARN    2
`define ILB_BIT_TH_LIMIT   1
`define ILB_BIT_TH_CUTOFF  0
`define ILB_GPIO_WARM      3'd4
`endif

// ==== design/ilb_pkg.sv ====
// Types shared by the event latch bank
package ilb_pkg;
   // Output-driver monitor conditions
   typedef struct packed {
      logic       spk_right_short;
      logic       spk_left_short;
      logic [5:0] hp_short;
      logic [7:0] on_done;
      logic [7:0] off_done;
      logic       thermal_warning;
      logic       thermal_limit;
      logic       spk_cutoff;
   } ilb_cond_type;
   // Bus access state
   typedef enum logic [1:0] {
      ILB_IDLE = 2'b01,
      ILB_RESP = 2'b10
   } ilb_bus_state_type;
endpackage

// ==== design/ilb_event_latch.sv ====
// Event latch bank with Avalon-MM slave access
// Operation
// - Flags stay set until host writes one; writing zero leaves them alone.
// - Speaker short flags bits 7 and 6 latch on both edges of condition.
// - Headphone short flags bits 5 to 0 latch on rising edge only.
// - Enable-done and disable-done flags latch on rising edge of completion.
// - Thermal warning bit 2 and limit bit 1 latch on rising edge.
// - Speaker cutoff flag bit 0 latches on both edges.
// - GPIO flags latch on any pin edge; pins 1-16 low, 17-32 mid register.
// - GPIO edge detection uses synchronised pin logic level of GPIO inputs.
// - Cutoff condition is shutdown completed, from overheat or short circuit.
`timescale 1ns/100ps
`include "ilb_defs.svh"
module ilb_event_latch
   import ilb_pkg::*;
(
   input  wire logic                      sys_clk,          // 250 MHz clock
   input  wire logic                      reset,            // Sync reset, high
   input  wire ilb_cond_type              cond,             // Driver monitor levels
   input  wire logic [31:0]               gpio_pin_level,   // GPIO input pins
   input  wire logic [`ILB_ADDR_W-1:0]    avs_address,      // Byte address
   input  wire logic                      avs_read,         // Read request
   input  wire logic                      avs_write,        // Write request
   input  wire logic [31:0]               avs_writedata,    // Write data
   input  wire logic [3:0]                avs_byteenable,   // Byte lanes
   output logic      [31:0]               avs_readdata,     // Read data
   output logic                           avs_waitrequest   // Stall
);
   localparam int NREG = 6;
   localparam logic [15:0] IDX [NREG] = '{`ILB_IDX_SHORT, `ILB_IDX_ON_DONE, `ILB_IDX_OFF_DONE,
                                          `ILB_IDX_THERMAL, `ILB_IDX_GPIO_LOW, `ILB_IDX_GPIO_MID};

   logic [15:0]       flag_q [NREG];
   logic [15:0]       flag_d [NREG];
   logic [15:0]       set_vec [NREG];
   logic [15:0]       clr_vec [NREG];
   ilb_cond_type      cond_q;
   logic [31:0]       gp_s1_q, gp_s2_q, gp_s3_q;
   logic [31:0]       gp_lvl_q, gp_lvl_d;
   logic [31:0]       gp_agree;
   logic [31:0]       gp_edge;
   logic [2:0]        gp_warm_q, gp_warm_d;
   ilb_bus_state_type st_q, st_d;
   logic [31:0]       rdata_q, rdata_d;
   logic              wait_q, wait_d;
   logic              wr_hit;
   logic [2:0]        sel;
   logic              sel_ok;

   // Condition history and GPIO three-stage synchroniser
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cond_q    <= '0;
         gp_s1_q   <= '0;
         gp_s2_q   <= '0;
         gp_s3_q   <= '0;
         gp_lvl_q  <= '0;
         gp_warm_q <= 3'd0;
      end else begin
         cond_q    <= cond;
         gp_s1_q   <= gpio_pin_level;
         gp_s2_q   <= gp_s1_q;
         gp_s3_q   <= gp_s2_q;
         gp_lvl_q  <= gp_lvl_d;
         gp_warm_q <= gp_warm_d;
      end
   end

   // Agreed pin level; edges ignored until the chain has filled
   always_comb begin
      gp_agree  = ~(gp_s2_q ^ gp_s3_q);
      gp_lvl_d  = (gp_lvl_q & ~gp_agree) | (gp_s3_q & gp_agree);
      gp_edge   = gp_agree & (gp_s3_q ^ gp_lvl_q) & {32{gp_warm_q == `ILB_GPIO_WARM}};
      gp_warm_d = gp_warm_q;
      if (gp_warm_q != `ILB_GPIO_WARM) begin
         gp_warm_d = gp_warm_q + 3'd1;
      end
   end

   // Edge detection per source
   always_comb begin
      set_vec[0] = 16'h0000;
      set_vec[0][`ILB_BIT_SPK_R] = cond.spk_right_short ^ cond_q.spk_right_short;
      set_vec[0][`ILB_BIT_SPK_L] = cond.spk_left_short ^ cond_q.spk_left_short;
      set_vec[0][`ILB_HP_MSB:0]  = cond.hp_short & ~cond_q.hp_short;
      set_vec[1] = {8'h00, cond.on_done & ~cond_q.on_done};
      set_vec[2] = {8'h00, cond.off_done & ~cond_q.off_done};
      set_vec[3] = 16'h0000;
      set_vec[3][`ILB_BIT_TH_WARN]  = cond.thermal_warning & ~cond_q.thermal_warning;
      set_vec[3][`ILB_BIT_TH_LIMIT] = cond.thermal_limit & ~cond_q.thermal_limit;
      set_vec[3][`ILB_BIT_TH_CUTOFF] = cond.spk_cutoff ^ cond_q.spk_cutoff;
      set_vec[4] = gp_edge[15:0];
      set_vec[5] = gp_edge[31:16];
   end

   // Address decode
   always_comb begin
      sel    = 3'd0;
      sel_ok = 1'b0;
      for (int i = 0; i < NREG; i++) begin
         if (avs_address == {IDX[i], 2'b00}) begin
            sel    = 3'(i);
            sel_ok = 1'b1;
         end
      end
   end

   assign wr_hit = (st_q == ILB_IDLE) && avs_write && sel_ok;

   // Sticky flags, write one to clear, set wins
   genvar g;
   generate
      for (g = 0; g < NREG; g++) begin : g_flag
         always_comb begin
            clr_vec[g] = 16'h0000;
            if (wr_hit && sel == 3'(g)) begin
               clr_vec[g] = avs_writedata[15:0] & {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
            end
            flag_d[g] = (flag_q[g] & ~clr_vec[g]) | set_vec[g];
         end
         always_ff @(posedge sys_clk) begin
            if (reset) begin
               flag_q[g] <= `ILB_REG_RESET;
            end else begin
               flag_q[g] <= flag_d[g];
            end
         end
      end
   endgenerate

   // Bus response: one wait cycle, then answer
   always_comb begin
      st_d    = st_q;
      rdata_d = rdata_q;
      wait_d  = 1'b1;
      case (st_q)
         ILB_IDLE: begin
            if (avs_read || avs_write) begin
               st_d    = ILB_RESP;
               wait_d  = 1'b0;
               rdata_d = 32'h0000_0000;
               if (avs_read && sel_ok) begin
                  rdata_d = {16'h0000, flag_q[sel]};
               end
            end
         end
         ILB_RESP: begin
            st_d = ILB_IDLE;
         end
         default: begin
            st_d = ILB_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_q    <= ILB_IDLE;
         rdata_q <= 32'h0000_0000;
         wait_q  <= 1'b1;
      end else begin
         st_q    <= st_d;
         rdata_q <= rdata_d;
         wait_q  <= wait_d;
      end
   end

   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = wait_q;

   // Named steps of a bus access
   sequence s_clear_write(int r);
      wr_hit && sel == 3'(r) && avs_writedata[0] && avs_byteenable[0];
   endsequence
   sequence s_take_read;
      st_q == ILB_IDLE && avs_read;
   endsequence
   sequence s_take_write;
      st_q == ILB_IDLE && avs_write;
   endsequence
   sequence s_one_wait;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence

   // Sticky flags and write-one-to-clear
   chk_flag_sticky: assert property (@(posedge sys_clk) disable iff (reset)
      (flag_q[0][7] && !(wr_hit && sel == 3'd0))
      |=> flag_q[0][7])
      else $error("flag dropped without clear");

   chk_clear_works: assert property (@(posedge sys_clk) disable iff (reset)
      (s_clear_write(1) and !set_vec[1][0])
      |=> !flag_q[1][0])
      else $error("write one did not clear");

   chk_zero_write: assert property (@(posedge sys_clk) disable iff (reset)
      (wr_hit && sel == 3'd1 && avs_writedata[7:0] == 8'h00 && flag_q[1][7])
      |=> flag_q[1][7])
      else $error("zero write cleared a flag");

   chk_lane_gate: assert property (@(posedge sys_clk) disable iff (reset)
      (wr_hit && sel == 3'd4 && !avs_byteenable[1] && flag_q[4][15])
      |=> flag_q[4][15])
      else $error("disabled lane cleared a flag");

   // Speaker short flags, both edges
   chk_spk_right_rise: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(cond.spk_right_short)
      |=> flag_q[0][7])
      else $error("right speaker short rise missed");

   chk_spk_right_fall: assert property (@(posedge sys_clk) disable iff (reset)
      $fell(cond.spk_right_short)
      |=> flag_q[0][7])
      else $error("right speaker short fall missed");

   chk_spk_left_rise: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(cond.spk_left_short)
      |=> flag_q[0][6])
      else $error("left speaker short rise missed");

   chk_spk_fall: assert property (@(posedge sys_clk) disable iff (reset)
      $fell(cond.spk_left_short)
      |=> flag_q[0][6])
      else $error("speaker short fall missed");

   // Headphone short flags, rising edge only
   for (g = 0; g < 6; g++) begin : g_hp_chk
      chk_hp_rise: assert property (@(posedge sys_clk) disable iff (reset)
         $rose(cond.hp_short[g])
         |=> flag_q[0][g])
         else $error("headphone short rise missed");
   end

   chk_hp_rise_only: assert property (@(posedge sys_clk) disable iff (reset)
      ($fell(cond.hp_short[0]) && !flag_q[0][0])
      |=> !flag_q[0][0])
      else $error("headphone short set on fall");

   // Sequence-done flags, rising edge only
   for (g = 0; g < 8; g++) begin : g_done_chk
      chk_on_rise: assert property (@(posedge sys_clk) disable iff (reset)
         $rose(cond.on_done[g])
         |=> flag_q[1][g])
         else $error("enable done rise missed");
      chk_off_rise: assert property (@(posedge sys_clk) disable iff (reset)
         $rose(cond.off_done[g])
         |=> flag_q[2][g])
         else $error("disable done rise missed");
   end

   chk_off_done: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(cond.off_done[7])
      |=> flag_q[2][7])
      else $error("off done missed");

   chk_on_fall_quiet: assert property (@(posedge sys_clk) disable iff (reset)
      ($fell(cond.on_done[0]) && !flag_q[1][0])
      |=> !flag_q[1][0])
      else $error("enable done set on fall");

   // Thermal flags
   chk_thermal_rise: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(cond.thermal_warning)
      |=> flag_q[3][2])
      else $error("thermal warning missed");

   chk_limit_rise: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(cond.thermal_limit)
      |=> flag_q[3][1])
      else $error("thermal limit missed");

   chk_warn_rise_only: assert property (@(posedge sys_clk) disable iff (reset)
      ($fell(cond.thermal_warning) && !flag_q[3][2])
      |=> !flag_q[3][2])
      else $error("thermal warning set on fall");

   chk_limit_rise_only: assert property (@(posedge sys_clk) disable iff (reset)
      ($fell(cond.thermal_limit) && !flag_q[3][1])
      |=> !flag_q[3][1])
      else $error("thermal limit set on fall");

   chk_cutoff_both: assert property (@(posedge sys_clk) disable iff (reset)
      $changed(cond.spk_cutoff)
      |=> flag_q[3][0])
      else $error("cutoff edge missed");

   chk_cutoff_rise: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(cond.spk_cutoff)
      |=> flag_q[3][0])
      else $error("cutoff rise missed");

   // GPIO change flags
   chk_gpio_latency: assert property (@(posedge sys_clk) disable iff (reset)
      (gp_warm_q == `ILB_GPIO_WARM && gp_agree[16] && (gp_s3_q[16] != gp_lvl_q[16]))
      |=> flag_q[5][0])
      else $error("pin 17 change missed");

   chk_gpio_low_edge: assert property (@(posedge sys_clk) disable iff (reset)
      gp_edge[0]
      |=> flag_q[4][0])
      else $error("pin 1 change missed");

   chk_gpio_level_change: assert property (@(posedge sys_clk) disable iff (reset)
      ($changed(gp_lvl_q[15]) && $past(gp_warm_q) == `ILB_GPIO_WARM)
      |-> flag_q[4][15])
      else $error("pin 16 change missed");

   chk_gpio_agree: assert property (@(posedge sys_clk) disable iff (reset)
      gp_agree[0]
      |=> gp_lvl_q[0] == $past(gp_s3_q[0]))
      else $error("agreed pin level not taken");

   // Reset and set-over-clear
   chk_set_wins: assert property (@(posedge sys_clk) disable iff (reset)
      (s_clear_write(4) and set_vec[4][0])
      |=> flag_q[4][0])
      else $error("clear beat set");

   chk_reset_flags: assert property (@(posedge sys_clk)
      reset
      |=> (flag_q[0] == 16'h0000 && flag_q[1] == 16'h0000 && flag_q[2] == 16'h0000 &&
           flag_q[3] == 16'h0000 && flag_q[4] == 16'h0000 && flag_q[5] == 16'h0000))
      else $error("flags not zero after reset");

   // Bus answer timing and data
   chk_bus_answer: assert property (@(posedge sys_clk) disable iff (reset)
      s_take_read
      |=> s_one_wait)
      else $error("bus answer timing");

   chk_write_answer: assert property (@(posedge sys_clk) disable iff (reset)
      s_take_write
      |=> s_one_wait)
      else $error("write answer timing");

   chk_unmapped_read: assert property (@(posedge sys_clk) disable iff (reset)
      (st_q == ILB_IDLE && avs_read && !sel_ok)
      |=> avs_readdata == 32'h0000_0000)
      else $error("unmapped read not zero");

   chk_read_data: assert property (@(posedge sys_clk) disable iff (reset)
      (st_q == ILB_IDLE && avs_read && sel_ok)
      |=> avs_readdata[15:0] == $past(flag_q[sel]))
      else $error("read data differs from flags");

   chk_upper_zero: assert property (@(posedge sys_clk) disable iff (reset)
      !avs_waitrequest
      |-> avs_readdata[31:16] == 16'h0000)
      else $error("upper read data not zero");

   chk_idle_wait: assert property (@(posedge sys_clk) disable iff (reset)
      (st_q == ILB_IDLE && !avs_read && !avs_write)
      |=> avs_waitrequest)
      else $error("answer without request");
endmodule // ilb_event_latch

// ==== sim/ilb_event_latch_tb.sv ====
// Self-checking bench for the event latch bank
`timescale 1ns/100ps
`include "ilb_defs.svh"
module ilb_event_latch_tb
   import ilb_pkg::*;
   ;
   logic         sys_clk, reset, avs_read, avs_write, avs_waitrequest;
   ilb_cond_type cond;
   logic [31:0]  gpio_pin_level, avs_writedata, avs_readdata, rd;
   logic [17:0]  avs_address;
   logic [3:0]   avs_byteenable;
   int           errors, check_count;
   // Device under test
   ilb_event_latch DUT (.sys_clk(sys_clk), .reset(reset), .cond(cond), .gpio_pin_level(gpio_pin_level),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   // Verdict and end of run
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // One bus cycle, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd, input logic [3:0] be);
      int n;
      n = 0;
      avs_address <= {idx, 2'b00};
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= wd;
      avs_byteenable <= be;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge sys_clk);
      if (n >= 50) begin
         errors++;
         wrap_up();
      end
   endtask
   // Read a register and compare
   task automatic rd_chk(input string name, input logic [15:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0000_0000, 4'hf);
      check_count++;
      if (rd !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, rd);
      end
   endtask
   task automatic settle();
      repeat (8) @(posedge sys_clk);
   endtask
   task automatic t_reset();
      rd_chk("short", `ILB_IDX_SHORT, 32'h0000_0000);
      rd_chk("on", `ILB_IDX_ON_DONE, 32'h0000_0000);
      rd_chk("off", `ILB_IDX_OFF_DONE, 32'h0000_0000);
      rd_chk("thermal", `ILB_IDX_THERMAL, 32'h0000_0000);
      rd_chk("gpio_low", `ILB_IDX_GPIO_LOW, 32'h0000_0000);
      rd_chk("gpio_mid", `ILB_IDX_GPIO_MID, 32'h0000_0000);
      rd_chk("unmapped", 16'h190f, 32'h0000_0000);
      $display("test reset done");
   endtask
   task automatic t_short();
      cond.spk_right_short <= 1'b1;
      cond.spk_left_short <= 1'b1;
      cond.hp_short <= 6'h3f;
      settle();
      rd_chk("short_rise", `ILB_IDX_SHORT, 32'h0000_00ff);
      bus(1'b1, `ILB_IDX_SHORT, 32'h0000_00ff, 4'hf);
      rd_chk("short_clr", `ILB_IDX_SHORT, 32'h0000_0000);
      cond.spk_right_short <= 1'b0;
      cond.spk_left_short <= 1'b0;
      cond.hp_short <= 6'h00;
      settle();
      rd_chk("short_fall", `ILB_IDX_SHORT, 32'h0000_00c0);
      bus(1'b1, `ILB_IDX_SHORT, 32'h0000_ffff, 4'hf);
      $display("test short done");
   endtask
   task automatic t_done();
      cond.on_done <= 8'hff;
      cond.off_done <= 8'h81;
      settle();
      rd_chk("on_rise", `ILB_IDX_ON_DONE, 32'h0000_00ff);
      rd_chk("off_rise", `ILB_IDX_OFF_DONE, 32'h0000_0081);
      bus(1'b1, `ILB_IDX_ON_DONE, 32'h0000_0000, 4'hf);
      rd_chk("on_w0", `ILB_IDX_ON_DONE, 32'h0000_00ff);
      bus(1'b1, `ILB_IDX_ON_DONE, 32'h0000_ffff, 4'hf);
      bus(1'b1, `ILB_IDX_OFF_DONE, 32'h0000_ffff, 4'hf);
      cond.on_done <= 8'h00;
      cond.off_done <= 8'h00;
      settle();
      rd_chk("on_fall", `ILB_IDX_ON_DONE, 32'h0000_0000);
      rd_chk("off_fall", `ILB_IDX_OFF_DONE, 32'h0000_0000);
      $display("test done flags done");
   endtask
   task automatic t_thermal();
      cond.thermal_warning <= 1'b1;
      cond.thermal_limit <= 1'b1;
      cond.spk_cutoff <= 1'b1;
      settle();
      rd_chk("th_rise", `ILB_IDX_THERMAL, 32'h0000_0007);
      bus(1'b1, `ILB_IDX_THERMAL, 32'h0000_ffff, 4'hf);
      cond.thermal_warning <= 1'b0;
      cond.thermal_limit <= 1'b0;
      cond.spk_cutoff <= 1'b0;
      settle();
      rd_chk("th_fall", `ILB_IDX_THERMAL, 32'h0000_0001);
      bus(1'b1, `ILB_IDX_THERMAL, 32'h0000_ffff, 4'hf);
      $display("test thermal done");
   endtask
   task automatic t_gpio();
      gpio_pin_level <= 32'h001f_ffff;
      settle();
      rd_chk("gp_low", `ILB_IDX_GPIO_LOW, 32'h0000_ffff);
      rd_chk("gp_mid", `ILB_IDX_GPIO_MID, 32'h0000_001f);
      bus(1'b1, `ILB_IDX_GPIO_LOW, 32'h0000_ffff, 4'h1);
      rd_chk("gp_lane", `ILB_IDX_GPIO_LOW, 32'h0000_ff00);
      bus(1'b1, `ILB_IDX_GPIO_LOW, 32'h0000_ffff, 4'hf);
      bus(1'b1, `ILB_IDX_GPIO_MID, 32'h0000_ffff, 4'hf);
      gpio_pin_level <= 32'h0000_0000;
      settle();
      rd_chk("gp_low_f", `ILB_IDX_GPIO_LOW, 32'h0000_ffff);
      rd_chk("gp_mid_f", `ILB_IDX_GPIO_MID, 32'h0000_001f);
      $display("test gpio done");
   endtask
   // Clock, 4 ns period
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // Main sequence
   initial begin
      reset = 1'b1;
      cond = '0;
      gpio_pin_level = 32'h0000_0000;
      {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
      repeat (16) @(posedge sys_clk);
      reset <= 1'b0;
      repeat (2) @(posedge sys_clk);
      t_reset();
      t_short();
      t_done();
      t_thermal();
      t_gpio();
      wrap_up();
   end
endmodule // ilb_event_latch_tb
